/* verilog/ocr_top.sv */
/*
 * Overcurrent response configuration slice of a three-phase gate driver: the registers that
 * choose how a drain-source overcurrent is handled, the write lock, and the open-drain fault pin.
 * Assumes the serial control port delivers byte reads and writes as one-cycle strobes on this
 * clock, and that the monitor, PWM and warning inputs come asynchronously from the analog side.
 */
`timescale 1ns/1ps
`default_nettype none
module ocr_top #(
    parameter int RETRY_CYCLES = ocr_pkg::RETRY_CYCLES
) (
    // Clock and reset
    input  wire logic                      sys_clk_i,
    input  wire logic                      rst_i,
    // Register access from the serial control port
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    input  wire logic [ocr_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [ocr_pkg::DATA_W-1:0] reg_wdata_i,
    output logic      [ocr_pkg::DATA_W-1:0] reg_rdata_o,
    output logic                           reg_rvalid_o,
    // Analog monitors and PWM inputs
    input  wire logic [2:0]                oc_high_i,
    input  wire logic [2:0]                oc_low_i,
    input  wire logic [2:0]                pwm_in_i,
    input  wire logic                      otw_i,
    // Gate control and fault pin
    output logic                           gate_shutdown_o,
    output logic                           ocp_fault_o,
    output logic                           fault_indicator_n_o,
    output logic                           fault_indicator_n_oe_o
);

    localparam int N_SYNC = 10;

    ocr_cfg_if cfg ();

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // A level only counts once the second and third stages agree, which also
    // rejects a single-cycle glitch on the comparator outputs.
    logic [N_SYNC-1:0] raw_in;
    logic [N_SYNC-1:0] sync_1;
    logic [N_SYNC-1:0] sync_2;
    logic [N_SYNC-1:0] sync_3;
    logic [N_SYNC-1:0] filt;

    assign raw_in = {otw_i, pwm_in_i, oc_low_i, oc_high_i};

    genvar gi;
    generate
        for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
            always_ff @(posedge sys_clk_i) begin
                if (rst_i) begin
                    sync_1[gi] <= 1'b0;
                    sync_2[gi] <= 1'b0;
                    sync_3[gi] <= 1'b0;
                    filt[gi]   <= 1'b0;
                end else begin
                    sync_1[gi] <= raw_in[gi];
                    sync_2[gi] <= sync_1[gi];
                    sync_3[gi] <= sync_2[gi];
                    if (sync_2[gi] == sync_3[gi]) begin
                        filt[gi] <= sync_3[gi];
                    end
                end
            end
        end
    endgenerate

    logic [2:0] oc_phase;
    logic [2:0] pwm_f;
    logic [2:0] pwm_prev;
    logic       otw_f;
    logic       pwm_event;

    // Both transistors of a phase share that phase's monitor mask.
    assign oc_phase  = filt[2:0] | filt[5:3];
    assign pwm_f     = filt[8:6];
    assign otw_f     = filt[9];
    assign pwm_event = |(pwm_f & ~pwm_prev);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pwm_prev <= 3'h0;
        end else begin
            pwm_prev <= pwm_f;
        end
    end

    // ----------------------------------------------------------------
    // Address decode and write gating
    // ----------------------------------------------------------------
    logic hit_status;
    logic hit_clear;
    logic hit_lock;
    logic hit_ctrl;
    logic hit_tune_a;
    logic hit_tune_b;
    logic wr_open;

    assign hit_status = (reg_addr_i == ocr_pkg::OFS_FAULT_STATUS);
    assign hit_clear  = (reg_addr_i == ocr_pkg::OFS_CLEAR);
    assign hit_lock   = (reg_addr_i == ocr_pkg::OFS_LOCK);
    assign hit_ctrl   = (reg_addr_i == ocr_pkg::OFS_OCR_CTRL);
    assign hit_tune_a = (reg_addr_i == ocr_pkg::OFS_TUNE_A);
    assign hit_tune_b = (reg_addr_i == ocr_pkg::OFS_TUNE_B);
    assign wr_open    = reg_wr_i & ~cfg.locked;

    assign cfg.wdata       = reg_wdata_i;
    assign cfg.wr_ctrl     = wr_open & hit_ctrl;
    assign cfg.wr_tune_a   = wr_open & hit_tune_a;
    assign cfg.wr_tune_b   = wr_open & hit_tune_b;
    assign cfg.wr_lock     = reg_wr_i & hit_lock;
    assign cfg.clear_pulse = reg_wr_i & hit_clear & reg_wdata_i[ocr_pkg::BIT_CLEAR];

    // ----------------------------------------------------------------
    // Storage and response
    // ----------------------------------------------------------------
    ocr_pkg::ocr_state_t fc_state;
    logic                fc_gate_off;
    logic                fc_report;
    logic                fc_oc_hit;

    ocr_regfile u_regfile (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .cfg       (cfg.regs)
    );

    ocr_fault_ctl #(
        .RETRY_CYCLES (RETRY_CYCLES)
    ) u_fault_ctl (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .cfg         (cfg.core),
        .oc_phase_i  (oc_phase),
        .pwm_event_i (pwm_event),
        .state_o     (fc_state),
        .gate_off_o  (fc_gate_off),
        .report_o    (fc_report),
        .oc_hit_o    (fc_oc_hit)
    );

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] status_val;
    logic [7:0] lock_val;
    logic [7:0] rd_mux;

    assign status_val = {3'h0, oc_phase & ~cfg.phase_dis, otw_f, fc_report};
    assign lock_val   = {(cfg.locked ? ocr_pkg::LOCK_SET : ocr_pkg::LOCK_CLR), 5'h00};
    assign rd_mux     = hit_status ? status_val :
                        hit_lock   ? lock_val   :
                        hit_ctrl   ? cfg.ctrl   :
                        hit_tune_a ? cfg.tune_a :
                        hit_tune_b ? cfg.tune_b : 8'h00;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Gate and fault pin outputs
    // ----------------------------------------------------------------
    // The pin is open drain: it is only ever pulled low, the external pull-up
    // provides the high level, so the data output stays at zero.
    logic next_fault_oe;

    assign next_fault_oe = fc_report | (otw_f & cfg.overtemp_warning_to_fault_pin);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            gate_shutdown_o        <= 1'b0;
            ocp_fault_o            <= 1'b0;
            fault_indicator_n_o    <= 1'b0;
            fault_indicator_n_oe_o <= 1'b0;
        end else begin
            gate_shutdown_o        <= fc_gate_off;
            ocp_fault_o            <= fc_report;
            fault_indicator_n_o    <= 1'b0;
            fault_indicator_n_oe_o <= next_fault_oe;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    otw_pin_on_a: assert property (otw_f && cfg.overtemp_warning_to_fault_pin |=> fault_indicator_n_oe_o)
        else $error("overtemperature warning not driven on fault pin");

    otw_pin_off_a: assert property (!fc_report && !cfg.overtemp_warning_to_fault_pin |=> !fault_indicator_n_oe_o)
        else $error("fault pin driven without a reported fault");

    cbc_clear_a: assert property (fc_state == ocr_pkg::ST_RETRY && cfg.cbc && pwm_event && !fc_oc_hit
                                  |=> fc_state == ocr_pkg::ST_IDLE ##1 !gate_shutdown_o)
        else $error("cycle clear did not release the retry fault");

    phase_mask_a: assert property (!fc_report && ((oc_phase & ~cfg.phase_dis) == 3'h0)
                                   |=> !fc_report)
        else $error("masked phase raised an overcurrent fault");

    latch_entry_a: assert property (fc_state == ocr_pkg::ST_IDLE && fc_oc_hit
                                    && cfg.mode == ocr_pkg::OCR_LATCH
                                    |=> fc_state == ocr_pkg::ST_LATCHED ##1 gate_shutdown_o)
        else $error("latched fault not taken");

    latch_hold_a: assert property (fc_state == ocr_pkg::ST_LATCHED && !cfg.clear_pulse
                                   |=> fc_state == ocr_pkg::ST_LATCHED)
        else $error("latched fault released without a clear");

    retry_entry_a: assert property (fc_state == ocr_pkg::ST_IDLE && fc_oc_hit
                                    && cfg.mode == ocr_pkg::OCR_RETRY
                                    |=> fc_state == ocr_pkg::ST_RETRY ##1 gate_shutdown_o)
        else $error("retry fault not taken");

    report_only_a: assert property (fc_state == ocr_pkg::ST_REPORT
                                    |=> !gate_shutdown_o && ocp_fault_o)
        else $error("report only mode touched the gates");

    ignore_mode_a: assert property (fc_state == ocr_pkg::ST_IDLE
                                    && cfg.mode == ocr_pkg::OCR_IGNORE
                                    |=> fc_state == ocr_pkg::ST_IDLE)
        else $error("ignored overcurrent changed state");

    ctrl_reset_a: assert property ($fell(rst_i) |-> cfg.ctrl == ocr_pkg::RST_OCR_CTRL)
        else $error("response control register reset value wrong");

    ctrl_write_a: assert property (reg_wr_i && hit_ctrl && !cfg.locked
                                   |=> cfg.ctrl == $past(reg_wdata_i))
        else $error("response control register write lost");

    tune_reset_a: assert property ($fell(rst_i) |-> cfg.tune_a == ocr_pkg::RST_TUNE_A)
        else $error("first tuning register reset value wrong");

    lock_block_a: assert property (cfg.locked && !(reg_wr_i && hit_lock)
                                   |=> $stable(cfg.ctrl) && $stable(cfg.tune_a) && cfg.locked)
        else $error("write took effect while locked");

    lock_set_a: assert property (reg_wr_i && hit_lock
                                 && reg_wdata_i[7:5] == ocr_pkg::LOCK_SET |=> cfg.locked)
        else $error("lock code did not lock");

    // A detection in the cycle of a clear keeps the fault, so the set always wins.
    latch_set_wins_a: assert property (fc_state == ocr_pkg::ST_LATCHED && fc_oc_hit
                                       |=> fc_state == ocr_pkg::ST_LATCHED)
        else $error("latched fault released during a detection");

    latch_clear_a: assert property (fc_state == ocr_pkg::ST_LATCHED && !fc_oc_hit
                                    && reg_wr_i && hit_clear && reg_wdata_i[ocr_pkg::BIT_CLEAR]
                                    |=> fc_state == ocr_pkg::ST_IDLE)
        else $error("clear write did not release the latched fault");

    retry_gate_a: assert property (fc_state == ocr_pkg::ST_RETRY
                                   |=> gate_shutdown_o && ocp_fault_o)
        else $error("retry fault not shown on the outputs");

    report_hold_a: assert property (fc_state == ocr_pkg::ST_REPORT && !cfg.clear_pulse
                                    |=> fc_state == ocr_pkg::ST_REPORT)
        else $error("reported fault dropped without a clear");

    ignore_quiet_a: assert property (fc_state == ocr_pkg::ST_IDLE && cfg.mode == ocr_pkg::OCR_IGNORE
                                     |=> !ocp_fault_o && !gate_shutdown_o)
        else $error("ignored overcurrent reached the outputs");

    ctrl_read_a: assert property (reg_rd_i && hit_ctrl
                                  |=> reg_rvalid_o && reg_rdata_o == $past(cfg.ctrl))
        else $error("response control register read back wrong");

    unlock_a: assert property (reg_wr_i && hit_lock
                               && reg_wdata_i[ocr_pkg::BIT_LOCK_MSB:ocr_pkg::BIT_LOCK_LSB] == ocr_pkg::LOCK_CLR
                               |=> !cfg.locked)
        else $error("unlock code did not unlock");

    lock_other_code_a: assert property (reg_wr_i && hit_lock
                                        && reg_wdata_i[7:5] != ocr_pkg::LOCK_SET
                                        && reg_wdata_i[7:5] != ocr_pkg::LOCK_CLR
                                        |=> $stable(cfg.locked))
        else $error("unknown lock code changed the lock");

    cov_latch_clear: cover property (fc_state == ocr_pkg::ST_LATCHED && cfg.clear_pulse
                                     ##1 fc_state == ocr_pkg::ST_IDLE);

    cov_cbc_release: cover property (fc_state == ocr_pkg::ST_RETRY && cfg.cbc && pwm_event);

    cov_locked_write: cover property (cfg.locked && reg_wr_i && hit_ctrl);

    cov_otw_report: cover property (otw_f && cfg.overtemp_warning_to_fault_pin ##1 fault_indicator_n_oe_o);

    cov_retry_expire: cover property (fc_state == ocr_pkg::ST_RETRY && !cfg.cbc
                                      ##1 fc_state == ocr_pkg::ST_IDLE);

endmodule
`default_nettype wire

/* pkg/ocr_pkg.sv */
/*
 * Shared constants and types of the overcurrent response configuration slice.
 * Assumes a 100 MHz logic clock and byte-wide register access from the serial control port.
 */
package ocr_pkg;

    // ----------------------------------------------------------------
    // Register access widths and offsets
    // ----------------------------------------------------------------
    localparam int         ADDR_W           = 5;
    localparam int         DATA_W           = 8;
    localparam logic [4:0] OFS_FAULT_STATUS = 5'h00;
    localparam logic [4:0] OFS_CLEAR        = 5'h04;
    localparam logic [4:0] OFS_LOCK         = 5'h0D;
    localparam logic [4:0] OFS_OCR_CTRL     = 5'h0E;
    localparam logic [4:0] OFS_TUNE_A       = 5'h0F;
    localparam logic [4:0] OFS_TUNE_B       = 5'h10;
    localparam logic [4:0] OFS_TUNE_C       = 5'h10;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_OCR_CTRL     = 8'h00;
    localparam logic [7:0] RST_TUNE_A       = 8'h2A;
    localparam logic [7:0] RST_TUNE_B       = 8'h7F;
    localparam logic [7:0] RST_TUNE_C       = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int         BIT_OVERTEMP_WARNING_TO_FAULT_PIN      = 6;
    localparam int         BIT_CBC          = 5;
    localparam int         BIT_DIS_LSB      = 2;
    localparam int         BIT_DIS_MSB      = 4;
    localparam int         BIT_MODE_LSB     = 0;
    localparam int         BIT_MODE_MSB     = 1;
    localparam int         BIT_LOCK_LSB     = 5;
    localparam int         BIT_LOCK_MSB     = 7;
    localparam int         BIT_CLEAR        = 7;
    localparam int         BIT_STAT_OCP     = 0;
    localparam int         BIT_STAT_OTW     = 1;
    localparam int         BIT_STAT_PH_LSB  = 2;
    localparam logic [2:0] LOCK_SET         = 3'h6;
    localparam logic [2:0] LOCK_CLR         = 3'h3;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int         CLK_MHZ          = 100;
    localparam int         RETRY_TIME_US    = 4000;
    localparam int         RETRY_CYCLES     = RETRY_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {
        OCR_LATCH  = 2'h0,
        OCR_RETRY  = 2'h1,
        OCR_REPORT = 2'h2,
        OCR_IGNORE = 2'h3
    } ocr_mode_t;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_LATCHED = 4'h2,
        ST_RETRY   = 4'h4,
        ST_REPORT  = 4'h8
    } ocr_state_t;

endpackage

/* pkg/ocr_cfg_if.sv */
/*
 * Carrier between the register storage and the fault controller.
 * Assumes the top module drives the write strobes and the clear pulse.
 */
`timescale 1ns/1ps
`default_nettype none
interface ocr_cfg_if;
    logic       wr_ctrl;
    logic       wr_tune_a;
    logic       wr_tune_b;
    logic       wr_lock;
    logic [7:0] wdata;
    logic [7:0] ctrl;
    logic [7:0] tune_a;
    logic [7:0] tune_b;
    logic [7:0] tune_c;
    logic       locked;
    logic [1:0] mode;
    logic       cbc;
    logic       overtemp_warning_to_fault_pin;
    logic [2:0] phase_dis;
    logic       clear_pulse;

    modport regs (input wr_ctrl, wr_tune_a, wr_tune_b, wr_lock, wdata,
                  output ctrl, tune_a, tune_b, tune_c, locked, mode, cbc, overtemp_warning_to_fault_pin, phase_dis);
    modport core (input mode, cbc, overtemp_warning_to_fault_pin, phase_dis, clear_pulse);
endinterface
`default_nettype wire

/* verilog/ocr_regfile.sv */
/*
 * Configuration register storage and the write lock.
 * Assumes decoded write strobes arrive already gated by the lock where needed.
 */
`timescale 1ns/1ps
`default_nettype none
module ocr_regfile (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Configuration carrier
    ocr_cfg_if.regs   cfg
);

    logic [2:0] lock_wr;

    assign lock_wr = cfg.wdata[ocr_pkg::BIT_LOCK_MSB:ocr_pkg::BIT_LOCK_LSB];

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cfg.ctrl   <= ocr_pkg::RST_OCR_CTRL;
            cfg.tune_a <= ocr_pkg::RST_TUNE_A;
            cfg.tune_b <= ocr_pkg::RST_TUNE_B;
            cfg.tune_c <= ocr_pkg::RST_TUNE_C;
        end else begin
            if (cfg.wr_ctrl) begin
                cfg.ctrl <= cfg.wdata;
            end
            if (cfg.wr_tune_a) begin
                cfg.tune_a <= cfg.wdata;
            end
            if (cfg.wr_tune_b) begin
                cfg.tune_b <= cfg.wdata;
                cfg.tune_c <= cfg.wdata;
            end
        end
    end

    // Patterns other than the two codes leave the lock as it stands.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cfg.locked <= 1'b0;
        end else if (cfg.wr_lock && lock_wr == ocr_pkg::LOCK_SET) begin
            cfg.locked <= 1'b1;
        end else if (cfg.wr_lock && lock_wr == ocr_pkg::LOCK_CLR) begin
            cfg.locked <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Field views
    // ----------------------------------------------------------------
    assign cfg.mode      = cfg.ctrl[ocr_pkg::BIT_MODE_MSB:ocr_pkg::BIT_MODE_LSB];
    assign cfg.cbc       = cfg.ctrl[ocr_pkg::BIT_CBC];
    assign cfg.overtemp_warning_to_fault_pin   = cfg.ctrl[ocr_pkg::BIT_OVERTEMP_WARNING_TO_FAULT_PIN];
    assign cfg.phase_dis = cfg.ctrl[ocr_pkg::BIT_DIS_MSB:ocr_pkg::BIT_DIS_LSB];

endmodule
`default_nettype wire

/* verilog/ocr_fault_ctl.sv */
/*
 * Drain-source overcurrent response state machine.
 * Assumes monitor inputs are already synchronised and the clear pulse lasts one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module ocr_fault_ctl #(
    parameter int RETRY_CYCLES = ocr_pkg::RETRY_CYCLES
) (
    // Clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_i,
    // Configuration
    ocr_cfg_if.core                   cfg,
    // Monitor events
    input  wire logic [2:0]           oc_phase_i,
    input  wire logic                 pwm_event_i,
    // Response
    output var  ocr_pkg::ocr_state_t  state_o,
    output logic                      gate_off_o,
    output logic                      report_o,
    output logic                      oc_hit_o
);

    localparam int CNT_W = (RETRY_CYCLES > 1) ? $clog2(RETRY_CYCLES) : 1;

    ocr_pkg::ocr_state_t state;
    ocr_pkg::ocr_state_t next_state;
    ocr_pkg::ocr_mode_t  mode_sel;
    logic [CNT_W-1:0]    retry_cnt;
    logic [CNT_W-1:0]    next_retry_cnt;
    logic                oc_hit;
    logic                retry_done;
    logic                cbc_clear;
    logic                release_retry;
    logic                release_clear;

    assign mode_sel      = ocr_pkg::ocr_mode_t'(cfg.mode);
    assign oc_hit        = |(oc_phase_i & ~cfg.phase_dis);
    assign retry_done    = (retry_cnt == '0);
    assign cbc_clear     = cfg.cbc & pwm_event_i;
    // A detection in the same cycle as any clear keeps the fault standing.
    assign release_retry = (retry_done | cbc_clear | cfg.clear_pulse) & ~oc_hit;
    assign release_clear = cfg.clear_pulse & ~oc_hit;

    always_comb begin
        next_state     = state;
        next_retry_cnt = retry_cnt;
        case (state)
            ocr_pkg::ST_IDLE: begin
                if (oc_hit) begin
                    case (mode_sel)
                        ocr_pkg::OCR_LATCH:  next_state = ocr_pkg::ST_LATCHED;
                        ocr_pkg::OCR_RETRY: begin
                            next_state     = ocr_pkg::ST_RETRY;
                            next_retry_cnt = CNT_W'(RETRY_CYCLES - 1);
                        end
                        ocr_pkg::OCR_REPORT: next_state = ocr_pkg::ST_REPORT;
                        default:             next_state = ocr_pkg::ST_IDLE;
                    endcase
                end
            end
            ocr_pkg::ST_LATCHED: begin
                if (release_clear) begin
                    next_state = ocr_pkg::ST_IDLE;
                end
            end
            ocr_pkg::ST_RETRY: begin
                if (release_retry) begin
                    next_state = ocr_pkg::ST_IDLE;
                end else if (!retry_done) begin
                    next_retry_cnt = retry_cnt - 1'b1;
                end
            end
            ocr_pkg::ST_REPORT: begin
                if (release_clear) begin
                    next_state = ocr_pkg::ST_IDLE;
                end
            end
            default: next_state = ocr_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state     <= ocr_pkg::ST_IDLE;
            retry_cnt <= '0;
        end else begin
            state     <= next_state;
            retry_cnt <= next_retry_cnt;
        end
    end

    assign state_o    = state;
    assign gate_off_o = (state == ocr_pkg::ST_LATCHED) | (state == ocr_pkg::ST_RETRY);
    assign report_o   = gate_off_o | (state == ocr_pkg::ST_REPORT);
    assign oc_hit_o   = oc_hit;

endmodule
`default_nettype wire

/* tb/ocr_host.sv */
/* Host model: drives the serial control port as one-cycle byte strobes.
   Assumes the clock of the block under test. */
`timescale 1ns/1ps
`default_nettype none
module ocr_host (
    // Clock
    input  wire logic       sys_clk_i,
    // Register access
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [4:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 5'h00;
        reg_wdata_o = 8'h00;
    end
    // One access, then an idle edge so strobes never rise twice in a step.
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d);
        reg_wr_o <= wr;
        reg_rd_o <= !wr;
        reg_addr_o <= a;
        reg_wdata_o <= (a == ocr_pkg::OFS_TUNE_A) ? (d & 8'h7F) : d;
        @(posedge sys_clk_i);
        reg_wr_o <= 1'b0;
        reg_rd_o <= 1'b0;
        @(posedge sys_clk_i);
    endtask
endmodule
`default_nettype wire

/* tb/overcurrent_response_config_regs_test.sv */
/* Self-checking bench of the overcurrent response slice.
   Assumes the host model in ocr_host and a short retry count. */
`timescale 1ns/1ps
`default_nettype none
module overcurrent_response_config_regs_test;
    logic       sys_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       reg_wr, reg_rd, reg_rvalid_o, gate_shutdown_o, ocp_fault_o, fault_n, fault_oe;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_o, v;
    logic [7:0] exp_q[$];
    logic [2:0] oc_high_i = 3'h0, oc_low_i = 3'h0, pwm_in_i = 3'h0;
    logic       otw_i = 1'b0;
    int         bad_count = 0, total_checks = 0;
    integer     seed = 81750;

    ocr_host host (.sys_clk_i(sys_clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
                   .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
    ocr_top #(.RETRY_CYCLES(40)) uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .oc_high_i(oc_high_i), .oc_low_i(oc_low_i), .pwm_in_i(pwm_in_i),
        .otw_i(otw_i), .gate_shutdown_o(gate_shutdown_o), .ocp_fault_o(ocp_fault_o),
        .fault_indicator_n_o(fault_n), .fault_indicator_n_oe_o(fault_oe));

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        host.access(1'b0, a, 8'h00);
    endtask
    task automatic pins(input logic g, input logic f);
        check({4'h0, fault_n, fault_oe, gate_shutdown_o, ocp_fault_o}, {4'h0, 1'b0, f, g, f});
    endtask

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // Read data is compared against the oldest noted expectation.
    always @(posedge sys_clk_i) begin
        if (reg_rvalid_o === 1'b1) check(reg_rdata_o, exp_q.pop_front());
    end
    initial begin
        #100us;
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        rd(ocr_pkg::OFS_OCR_CTRL, 8'h00);
        rd(ocr_pkg::OFS_TUNE_A, 8'h2A);
        v = 8'($random(seed));
        host.access(1'b1, ocr_pkg::OFS_OCR_CTRL, v);
        rd(ocr_pkg::OFS_OCR_CTRL, v);
        host.access(1'b1, ocr_pkg::OFS_LOCK, 8'hC0);
        host.access(1'b1, ocr_pkg::OFS_OCR_CTRL, ~v);
        rd(ocr_pkg::OFS_OCR_CTRL, v);
        host.access(1'b1, ocr_pkg::OFS_LOCK, 8'h60);
        rd(ocr_pkg::OFS_LOCK, 8'h60);
        for (int m = 0; m < 4; m++) begin
            host.access(1'b1, ocr_pkg::OFS_OCR_CTRL, 8'(m));
            oc_high_i <= 3'h1;
            repeat (10) @(posedge sys_clk_i);
            pins(m < 2, m < 3);
            oc_high_i <= 3'h0;
            repeat (60) @(posedge sys_clk_i);
            pins(m == 0, m == 0 || m == 2);
            host.access(1'b1, ocr_pkg::OFS_CLEAR, 8'h80);
            repeat (4) @(posedge sys_clk_i);
            pins(1'b0, 1'b0);
        end
        for (int p = 0; p < 3; p++) begin
            host.access(1'b1, ocr_pkg::OFS_OCR_CTRL, 8'h04 << p);
            oc_low_i <= 3'h1 << p;
            repeat (10) @(posedge sys_clk_i);
            pins(1'b0, 1'b0);
            oc_low_i <= 3'h0;
            repeat (8) @(posedge sys_clk_i);
        end
        host.access(1'b1, ocr_pkg::OFS_OCR_CTRL, 8'h21);
        oc_high_i <= 3'h2;
        repeat (8) @(posedge sys_clk_i);
        oc_high_i <= 3'h0;
        repeat (8) @(posedge sys_clk_i);
        pins(1'b1, 1'b1);
        rd(ocr_pkg::OFS_FAULT_STATUS, 8'h01);
        pwm_in_i <= 3'h4;
        repeat (10) @(posedge sys_clk_i);
        pins(1'b0, 1'b0);
        otw_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        check({7'h0, fault_oe}, 8'h00);
        host.access(1'b1, ocr_pkg::OFS_OCR_CTRL, 8'h40);
        repeat (4) @(posedge sys_clk_i);
        check({7'h0, fault_oe}, 8'h01);
        end_of_test();
    end
endmodule
`default_nettype wire
